//--- rtl/fcs_sequencer.sv
// flash command sequencer: wishbone registers, command checks, array sequencing
// How it works
// - block erase, verify, then completion flag
// - erase index wrong, or sector erase in restricted mode, gives access error
// - bad block or misalignment gives access error
// - protected block refuses erase, flags violation
// - verify errors set the first verify flag, uncorrectable ones set both
// - sector erase, verify, then completion flag
// - divider write sets the loaded flag
// - no divider loaded: refuse, access error
// - busy: no launch, command writes discarded
// - twenty byte registers at indices 0 to 19
// - test reserved registers read zero, ignore writes
// - indices two to five hold data words
// - program needs index five and phrase alignment
// - program into protected region flags violation
// - one-time program writes eight phrases once
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
module fcs_sequencer
	import fcs_pkg::*;
(
	// clock and reset
	input  wire logic                clock,
	input  wire logic                srst,
	// wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// operating mode
	input  wire logic                mode_restricted,
	// flash array
	output logic                     array_tick,
	output logic                     array_start,
	output fcs_pkg::fcs_op_e         array_op,
	output fcs_pkg::fcs_scope_e      array_scope,
	output logic      [17:0]         array_addr,
	output logic      [63:0]         array_data,
	input  wire logic                array_done,
	input  wire logic                array_err,
	input  wire logic                array_uncorr
);
	// bus state
	logic        pend_reg, pend_next, ack_next;
	logic [31:0] dat_next;
	// register and sequencer state
	logic [6:0]  div_reg, div_next;
	logic        loaded_reg, loaded_next;
	logic [2:0]  cidx_reg, cidx_next, lidx_reg, lidx_next;
	logic [4:0]  prot_reg, prot_next;
	logic        command_complete_flag_reg, command_complete_flag_next, acc_reg, acc_next, pv_reg, pv_next;
	logic        ve_reg, ve_next, vu_reg, vu_next;
	logic [7:0]  otp_used_reg, otp_used_next;
	logic [2:0]  ld_cnt_reg, ld_cnt_next;
	logic [1:0]  step_reg, step_next;
	logic [15:0] word_reg [CMD_WORDS];
	logic [15:0] word_next [CMD_WORDS];
	fcs_state_e  state_reg, state_next;
	logic        start_next;
	fcs_op_e     op_next, op_sel;
	fcs_scope_e  scope_next;
	logic [17:0] addr_next;
	logic [63:0] data_next;
	// decode and check terms
	logic [4:0]  reg_idx;
	logic        hit, wr, launch, mem_we, acc_hit, pv_hit, valid_blk, prot_any, prot_rgn;
	logic [7:0]  code, status_byte;
	logic [17:0] gaddr;
	logic [15:0] mem_a_data, mem_b_data;

	fcs_cmd_mem #(.W(16), .DEPTH(CMD_WORDS), .AW(3)) u_mem (
		.clock   (clock),
		.wr_en   (mem_we),
		.wr_be   ({(reg_idx == IDX_CMD_HI), (reg_idx == IDX_CMD_LO)}),
		.wr_addr (cidx_reg),
		.wr_data ({wb_dat_i[7:0], wb_dat_i[7:0]}),
		.a_addr  (cidx_reg),
		.a_data  (mem_a_data),
		.b_addr  (ld_cnt_reg),
		.b_data  (mem_b_data)
	);

	fcs_timebase #(.DW(7)) u_tb (
		.clock   (clock),
		.srst    (srst),
		.enable  (loaded_reg),
		.divisor (div_reg),
		.tick    (array_tick)
	);

	assign reg_idx     = wb_adr_i[6:2];
	assign hit         = !wb_adr_i[7] && (reg_idx < REG_COUNT);
	assign wr          = pend_reg && wb_we_i && wb_sel_i[0] && hit;
	assign status_byte = {command_complete_flag_reg, 1'b0, acc_reg, pv_reg, 2'b00, ve_reg, vu_reg};
	assign mem_we      = wr && command_complete_flag_reg && ((reg_idx == IDX_CMD_HI) || (reg_idx == IDX_CMD_LO));
	// launch is refused while an access error or protection violation from the last sequence is still pending
	assign launch      = wr && (reg_idx == IDX_STATUS) && wb_dat_i[ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg
	                     && !acc_reg && !pv_reg;

	// bus: request seen, then data and ack one cycle later
	always_comb begin
		pend_next = wb_cyc_i && wb_stb_i && !pend_reg && !wb_ack_o;
		ack_next  = pend_reg;
		dat_next  = wb_dat_o;
		if (pend_reg) begin
			dat_next = 32'h0000_0000;
			if (hit && !wb_we_i) begin
				case (reg_idx)
					IDX_CLKDIV: dat_next[7:0] = {loaded_reg, div_reg};
					IDX_CMDIDX: dat_next[7:0] = {5'h00, cidx_reg};
					IDX_STATUS: dat_next[7:0] = status_byte;
					IDX_PROT:   dat_next[7:0] = {3'h0, prot_reg};
					IDX_CMD_HI: dat_next[7:0] = mem_a_data[15:8];
					IDX_CMD_LO: dat_next[7:0] = mem_a_data[7:0];
					default:    dat_next[7:0] = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pend_reg <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			pend_reg <= pend_next;
			wb_ack_o <= ack_next;
			wb_dat_o <= dat_next;
		end
	end

	// command fields as captured at load
	assign code  = word_reg[0][15:8];
	assign gaddr = {word_reg[0][1:0], word_reg[1]};
	assign valid_blk = (gaddr[17:16] == BLK_EE) || (gaddr[17:16] == BLK_PF);
	assign prot_any  = (gaddr[17:16] == BLK_PF) ? (|prot_reg[3:0]) : prot_reg[PROT_EE];
	assign prot_rgn  = (gaddr[17:16] == BLK_PF) ? prot_reg[gaddr[15:14]] : prot_reg[PROT_EE];

	always_comb begin
		acc_hit = 1'b0;
		pv_hit  = 1'b0;
		if (!loaded_reg) begin
			acc_hit = 1'b1;
		end
		case (code)
			CMD_BLK, CMD_SEC: begin
				if ((lidx_reg != CI_ERASE) || !valid_blk || (mode_restricted && code == CMD_SEC)
				    || ((gaddr[17:16] == BLK_PF) && (gaddr[2:0] != 3'h0))
				    || ((gaddr[17:16] == BLK_EE) && gaddr[0])) begin
					acc_hit = 1'b1;
				end
				pv_hit = (code == CMD_BLK) ? prot_any : prot_rgn;
			end
			CMD_PROG: begin
				if ((lidx_reg != CI_PROG) || !valid_blk || mode_restricted
				    || (gaddr[2:0] != 3'h0)) begin
					acc_hit = 1'b1;
				end
				pv_hit = prot_rgn;
			end
			CMD_OTP: begin
				if ((lidx_reg != CI_PROG) || mode_restricted || (word_reg[1] > OTP_MAX)
				    || otp_used_reg[word_reg[1][2:0]]) begin
					acc_hit = 1'b1;
				end
			end
			default: acc_hit = 1'b1;
		endcase
	end

	// operation for each step; one-time program checks erased before writing
	always_comb begin
		case (code)
			CMD_BLK, CMD_SEC: op_sel = (step_reg == 2'd0) ? OP_ERASE
			                         : (step_reg == 2'd1) ? OP_VERIFY : OP_NONE;
			CMD_PROG:         op_sel = (step_reg == 2'd0) ? OP_PROG
			                         : (step_reg == 2'd1) ? OP_VERIFY : OP_NONE;
			CMD_OTP:          op_sel = (step_reg == 2'd1) ? OP_PROG
			                         : (step_reg == 2'd3) ? OP_NONE : OP_VERIFY;
			default:          op_sel = OP_NONE;
		endcase
	end

	always_comb begin
		div_next      = div_reg;
		loaded_next   = loaded_reg;
		cidx_next     = cidx_reg;
		lidx_next     = lidx_reg;
		prot_next     = prot_reg;
		command_complete_flag_next     = command_complete_flag_reg;
		acc_next      = acc_reg;
		pv_next       = pv_reg;
		ve_next       = ve_reg;
		vu_next       = vu_reg;
		otp_used_next = otp_used_reg;
		ld_cnt_next   = ld_cnt_reg;
		step_next     = step_reg;
		state_next    = state_reg;
		start_next    = 1'b0;
		op_next       = array_op;
		scope_next    = array_scope;
		addr_next     = array_addr;
		data_next     = array_data;
		for (int i = 0; i < CMD_WORDS; i++) begin
			word_next[i] = word_reg[i];
		end
		// software writes; configuration is frozen while a command runs
		if (wr && command_complete_flag_reg) begin
			case (reg_idx)
				IDX_CLKDIV: begin
					div_next = wb_dat_i[6:0];
					loaded_next = 1'b1;
				end
				IDX_CMDIDX: cidx_next = wb_dat_i[2:0];
				IDX_PROT:   prot_next = wb_dat_i[4:0];
				default: ;
			endcase
		end
		if (wr && (reg_idx == IDX_STATUS)) begin
			if (wb_dat_i[ST_ACC]) acc_next = 1'b0;
			if (wb_dat_i[ST_PV]) pv_next = 1'b0;
		end
		if (launch) begin
			command_complete_flag_next   = 1'b0;
			ve_next     = 1'b0;
			vu_next     = 1'b0;
			lidx_next   = cidx_reg;
			ld_cnt_next = 3'h0;
			state_next  = ST_LOAD;
		end
		// sequencer; its flag sets come last so they win over a clear
		case (state_reg)
			ST_IDLE: ;
			ST_LOAD: begin
				if (ld_cnt_reg != 3'h0) begin
					word_next[ld_cnt_reg - 3'h1] = mem_b_data;
				end
				ld_cnt_next = ld_cnt_reg + 3'h1;
				if (ld_cnt_reg == LOAD_END) begin
					state_next = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (acc_hit) acc_next = 1'b1;
				if (pv_hit) pv_next = 1'b1;
				step_next  = 2'd0;
				state_next = (acc_hit || pv_hit) ? ST_DONE : ST_ISSUE;
			end
			ST_ISSUE: begin
				if (op_sel == OP_NONE) begin
					state_next = ST_DONE;
				end else begin
					start_next = 1'b1;
					op_next    = op_sel;
					data_next  = {word_reg[2], word_reg[3], word_reg[4], word_reg[5]};
					addr_next  = gaddr;
					case (code)
						CMD_BLK:  scope_next = SC_BLOCK;
						CMD_SEC:  scope_next = SC_SECTOR;
						CMD_PROG: scope_next = SC_PHRASE;
						default: begin
							scope_next = SC_OTP;
							addr_next  = {15'h0000, word_reg[1][2:0]};
						end
					endcase
					if (code == CMD_OTP && op_sel == OP_PROG) begin
						otp_used_next[word_reg[1][2:0]] = 1'b1;
					end
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (array_done) begin
					step_next  = step_reg + 2'd1;
					state_next = ST_ISSUE;
					if (array_op == OP_VERIFY) begin
						ve_next = ve_reg | array_err | array_uncorr;
						vu_next = vu_reg | array_uncorr;
						if (code == CMD_OTP && step_reg == 2'd0 && (array_err || array_uncorr)) begin
							state_next = ST_DONE;
						end
					end
				end
			end
			ST_DONE: begin
				command_complete_flag_next  = 1'b1;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			div_reg      <= DIV_RST;
			loaded_reg   <= 1'b0;
			cidx_reg     <= CIDX_RST;
			lidx_reg     <= CIDX_RST;
			prot_reg     <= PROT_RST;
			command_complete_flag_reg     <= 1'b1;
			acc_reg      <= 1'b0;
			pv_reg       <= 1'b0;
			ve_reg       <= 1'b0;
			vu_reg       <= 1'b0;
			otp_used_reg <= 8'h00;
			ld_cnt_reg   <= 3'h0;
			step_reg     <= 2'd0;
			state_reg    <= ST_IDLE;
			array_start  <= 1'b0;
			array_op     <= OP_NONE;
			array_scope  <= SC_BLOCK;
			array_addr   <= 18'h00000;
			array_data   <= 64'h0000_0000_0000_0000;
			for (int i = 0; i < CMD_WORDS; i++) begin
				word_reg[i] <= 16'h0000;
			end
		end else begin
			div_reg      <= div_next;
			loaded_reg   <= loaded_next;
			cidx_reg     <= cidx_next;
			lidx_reg     <= lidx_next;
			prot_reg     <= prot_next;
			command_complete_flag_reg     <= command_complete_flag_next;
			acc_reg      <= acc_next;
			pv_reg       <= pv_next;
			ve_reg       <= ve_next;
			vu_reg       <= vu_next;
			otp_used_reg <= otp_used_next;
			ld_cnt_reg   <= ld_cnt_next;
			step_reg     <= step_next;
			state_reg    <= state_next;
			array_start  <= start_next;
			array_op     <= op_next;
			array_scope  <= scope_next;
			array_addr   <= addr_next;
			array_data   <= data_next;
			for (int i = 0; i < CMD_WORDS; i++) begin
				word_reg[i] <= word_next[i];
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	launch_clears_a: assert property (launch |=> !command_complete_flag_reg ##7 state_reg == ST_CHECK)
		else $error("launch did not start the load phase");
	div_loaded_a: assert property (wr && command_complete_flag_reg && reg_idx == IDX_CLKDIV |=> loaded_reg)
		else $error("divider write did not set loaded flag");
	no_div_a: assert property (state_reg == ST_CHECK && !loaded_reg |=> acc_reg ##1 command_complete_flag_reg)
		else $error("command ran without a loaded divider");
	busy_drop_a: assert property (!command_complete_flag_reg |-> !mem_we ##1 $stable(cidx_reg))
		else $error("command object written while busy");
	blk_index_a: assert property (state_reg == ST_CHECK && code == CMD_BLK
		&& lidx_reg != CI_ERASE |=> acc_reg && state_reg == ST_DONE)
		else $error("bad erase index not flagged");
	blk_align_a: assert property (state_reg == ST_CHECK && code == CMD_SEC
		&& gaddr[17:16] == BLK_PF && gaddr[2:0] != 3'h0 |=> acc_reg)
		else $error("misaligned erase address not flagged");
	prog_align_a: assert property (state_reg == ST_CHECK && code == CMD_PROG
		&& gaddr[2:0] != 3'h0 |=> acc_reg ##1 command_complete_flag_reg)
		else $error("misaligned program address not flagged");
	blk_prot_a: assert property (state_reg == ST_CHECK && code == CMD_BLK && prot_any
		|=> pv_reg && !array_start ##1 command_complete_flag_reg)
		else $error("protected block erase not refused");
	prog_prot_a: assert property (state_reg == ST_CHECK && code == CMD_PROG && prot_rgn
		|=> pv_reg)
		else $error("protected program not flagged");
	verify_flag_a: assert property (state_reg == ST_WAIT && array_done && array_op == OP_VERIFY
		&& array_uncorr |=> ve_reg && vu_reg)
		else $error("verify error not reported");
	command_complete_flag_source_a: assert property ($rose(command_complete_flag_reg) |-> $past(state_reg) == ST_DONE)
		else $error("completion flag set before sequence end");
	erase_first_a: assert property (state_reg == ST_CHECK && !acc_hit && !pv_hit
		&& code == CMD_SEC |=> ##1 array_start && array_op == OP_ERASE)
		else $error("sector erase did not start with erase");
	sticky_a: assert property (acc_reg && !(wr && reg_idx == IDX_STATUS) |=> acc_reg)
		else $error("access error flag dropped without clear");
	rsvd_zero_a: assert property (pend_reg && !wb_we_i && (reg_idx == IDX_RSV1
		|| reg_idx == IDX_RSV2) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
		else $error("reserved register read nonzero");
	otp_once_a: assert property (state_reg == ST_CHECK && code == CMD_OTP
		&& otp_used_reg[word_reg[1][2:0]] |=> acc_reg)
		else $error("second one-time program not refused");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	blk_done_c: cover property (state_reg == ST_DONE && code == CMD_BLK && !acc_reg && !pv_reg);
	prog_done_c: cover property (state_reg == ST_DONE && code == CMD_PROG && !acc_reg);
	otp_done_c: cover property (state_reg == ST_DONE && code == CMD_OTP && otp_used_reg != 8'h00);
	verify_err_c: cover property (command_complete_flag_reg && ve_reg);
endmodule : fcs_sequencer

//--- rtl/fcs_pkg.sv
// shared constants and types of the flash command sequencer
package fcs_pkg;
	// register indices; byte address is four times the index
	localparam logic [4:0] REG_COUNT  = 5'h14;
	localparam logic [4:0] IDX_CLKDIV = 5'h00;
	localparam logic [4:0] IDX_CMDIDX = 5'h02;
	localparam logic [4:0] IDX_STATUS = 5'h06;
	localparam logic [4:0] IDX_PROT   = 5'h08;
	localparam logic [4:0] IDX_CMD_HI = 5'h0A;
	localparam logic [4:0] IDX_CMD_LO = 5'h0B;
	localparam logic [4:0] IDX_RSV1   = 5'h0C;
	localparam logic [4:0] IDX_RSV2   = 5'h0D;
	// field positions
	localparam int ST_COMMAND_COMPLETE_FLAG    = 7;
	localparam int ST_ACC     = 5;
	localparam int ST_PV      = 4;
	localparam int ST_VE      = 1;
	localparam int ST_VU      = 0;
	localparam int DIV_LD_BIT = 7;
	localparam int PROT_EE    = 4;
	// values after reset
	localparam logic [6:0] DIV_RST  = 7'h00;
	localparam logic [2:0] CIDX_RST = 3'h0;
	localparam logic [4:0] PROT_RST = 5'h00;
	// command codes and parameters
	localparam logic [7:0]  CMD_PROG  = 8'h06;
	localparam logic [7:0]  CMD_OTP   = 8'h07;
	localparam logic [7:0]  CMD_BLK   = 8'h09;
	localparam logic [7:0]  CMD_SEC   = 8'h0A;
	localparam logic [1:0]  BLK_EE    = 2'h0;
	localparam logic [1:0]  BLK_PF    = 2'h3;
	localparam logic [2:0]  CI_ERASE  = 3'h1;
	localparam logic [2:0]  CI_PROG   = 3'h5;
	localparam logic [15:0] OTP_MAX   = 16'h0007;
	localparam int          CMD_WORDS = 6;
	localparam logic [2:0]  LOAD_END  = 3'h6;

	typedef enum logic [1:0] {
		OP_NONE   = 2'b00,
		OP_ERASE  = 2'b01,
		OP_PROG   = 2'b10,
		OP_VERIFY = 2'b11
	} fcs_op_e;

	typedef enum logic [1:0] {
		SC_BLOCK  = 2'b00,
		SC_SECTOR = 2'b01,
		SC_PHRASE = 2'b10,
		SC_OTP    = 2'b11
	} fcs_scope_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_CHECK = 3'b010,
		ST_ISSUE = 3'b011,
		ST_WAIT  = 3'b100,
		ST_DONE  = 3'b101
	} fcs_state_e;
endpackage : fcs_pkg

//--- rtl/fcs_cmd_mem.sv
// command object storage: byte-writable words, two registered read ports
`timescale 1ns/10ps
module fcs_cmd_mem #(
	parameter int W     = 16,
	parameter int DEPTH = 6,
	parameter int AW    = 3
) (
	// clock
	input  wire logic            clock,
	// write port
	input  wire logic            wr_en,
	input  wire logic [W/8-1:0]  wr_be,
	input  wire logic [AW-1:0]   wr_addr,
	input  wire logic [W-1:0]    wr_data,
	// read ports
	input  wire logic [AW-1:0]   a_addr,
	output logic      [W-1:0]    a_data,
	input  wire logic [AW-1:0]   b_addr,
	output logic      [W-1:0]    b_data
);
	genvar g;
	generate
		for (g = 0; g < W / 8; g++) begin : g_lane
			// each byte lane is its own array so every lane has a single writer
			logic [7:0] lane_mem [DEPTH];

			always_ff @(posedge clock) begin
				if (wr_en && wr_be[g] && (int'(wr_addr) < DEPTH)) begin
					lane_mem[wr_addr] <= wr_data[g*8 +: 8];
				end
			end

			// out-of-range indices read as zero
			always_ff @(posedge clock) begin
				a_data[g*8 +: 8] <= (int'(a_addr) < DEPTH) ? lane_mem[a_addr] : 8'h00;
				b_data[g*8 +: 8] <= (int'(b_addr) < DEPTH) ? lane_mem[b_addr] : 8'h00;
			end
		end
	endgenerate
endmodule : fcs_cmd_mem

//--- rtl/fcs_timebase.sv
// program time base: one tick every divisor+1 bus clocks once loaded
`timescale 1ns/10ps
module fcs_timebase #(
	parameter int DW = 7
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          srst,
	// control
	input  wire logic          enable,
	input  wire logic [DW-1:0] divisor,
	// time base
	output logic               tick
);
	logic [DW-1:0] count_reg;
	logic [DW-1:0] count_next;
	logic          tick_next;

	always_comb begin
		count_next = count_reg;
		tick_next  = 1'b0;
		if (!enable) begin
			count_next = '0;
		end else if (count_reg >= divisor) begin
			count_next = '0;
			tick_next  = 1'b1;
		end else begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			count_reg <= '0;
			tick      <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick      <= tick_next;
		end
	end
endmodule : fcs_timebase

//--- tb/fcs_flash_model.sv
// flash array stand-in that answers each start after a short or long wait
`timescale 1ns/10ps
module fcs_flash_model
	import fcs_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// from the sequencer
	input  wire logic        array_start,
	input  fcs_pkg::fcs_op_e array_op,
	// scenario control
	input  wire logic        slow,
	input  wire logic [1:0]  bad,
	// answer and log
	output logic             array_done,
	output logic             array_err,
	output logic             array_uncorr,
	output logic [7:0]       hist,
	output logic [7:0]       nst
);
	logic [5:0] cnt;
	logic       tgl;
	fcs_op_e    op;
	// outside a done pulse the flags wobble, so a stale level is never trusted
	assign array_err    = array_done ? (bad[1] & (op == OP_VERIFY)) : tgl;
	assign array_uncorr = array_done ? (bad[0] & (op == OP_VERIFY)) : ~tgl;
	always_ff @(posedge clock) begin
		if (srst) begin
			tgl <= 1'b0;
			cnt <= 6'h00;
			array_done <= 1'b0;
			hist <= 8'h00;
			nst <= 8'h00;
			op <= OP_NONE;
		end else begin
			tgl <= ~tgl;
			// one done per start, never in the start cycle
			array_done <= (cnt == 6'h01);
			if (array_start) begin
				cnt <= slow ? 6'h28 : 6'h03;
				op <= array_op;
				hist <= {hist[5:0], array_op};
				nst <= nst + 8'h01;
			end else if (cnt != 6'h00) begin
				cnt <= cnt - 6'h01;
			end
		end
	end
endmodule : fcs_flash_model

//--- tb/tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`define CK(n, e, v) begin checks++; if ((v) !== (e)) begin err_count++; \
	$display("wrong value %s exp %h got %h", n, e, v); end end
module tb;
	import fcs_pkg::*;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic        mode = 1'b0;
	logic        slow = 1'b0;
	logic [1:0]  bad = 2'h0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        start, done, err, unc;
	fcs_op_e     op;
	fcs_scope_e  scope;
	logic [17:0] addr;
	logic [63:0] data;
	logic [7:0]  hist, nst;
	logic        tick;
	int          ticks = 0;
	int          t0;
	int          err_count = 0;
	int          checks = 0;

	always #50 clock = ~clock;

	// count time base pulses seen by the array
	always @(posedge clock) begin
		if (tick === 1'b1) begin
			ticks <= ticks + 1;
		end
	end

	fcs_sequencer DUT (.clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_restricted(mode),
		.array_tick(tick), .array_start(start), .array_op(op), .array_scope(scope),
		.array_addr(addr), .array_data(data), .array_done(done), .array_err(err),
		.array_uncorr(unc));
	fcs_flash_model FM (.clock(clock), .srst(srst), .array_start(start), .array_op(op),
		.slow(slow), .bad(bad), .array_done(done), .array_err(err),
		.array_uncorr(unc), .hist(hist), .nst(nst));

	task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		sel <= 4'h1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		// no cycle count assumed; only the watchdog ends this wait
		do begin
			@(posedge clock);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
	endtask : wb
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, i, d, q);
	endtask : wr
	task automatic rc(input logic [5:0] i, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, i, 8'h00, q);
		`CK("register", e, q)
	endtask : rc
	task automatic cmd(input logic [2:0] last, input logic [15:0] w0, w1, w2, w3, w4, w5);
		logic [15:0] w[6];
		w = '{w0, w1, w2, w3, w4, w5};
		for (int k = 0; k <= last; k++) begin
			wr(IDX_CMDIDX, 8'(k));
			wr(IDX_CMD_HI, w[k][15:8]);
			wr(IDX_CMD_LO, w[k][7:0]);
		end
		wr(IDX_CMDIDX, {5'h0, last});
	endtask : cmd
	// poll until the sequence reports complete, then compare the status byte
	task automatic fin(input logic [7:0] e);
		logic [7:0] q;
		int n;
		n = 0;
		do begin
			wb(1'b0, IDX_STATUS, 8'h00, q);
			n++;
		end while (q[ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 200);
		if (q[ST_COMMAND_COMPLETE_FLAG] !== 1'b1) begin
			err_count++;
			end_of_test();
		end
		`CK("status", e, q)
	endtask : fin
	task automatic go(input logic [7:0] e);
		wr(IDX_STATUS, 8'h80);
		fin(e);
	endtask : go
	task automatic tdone(input int t);
		$display("test %0d done", t);
	endtask : tdone
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// tests need about 1,200 cycles; the limit allows 20,000
	initial begin
		#2000000;
		err_count++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		rc(IDX_STATUS, 8'h80);
		rc(IDX_CLKDIV, 8'h00);
		`CK("ticks", 0, ticks)
		wr(IDX_RSV1, 8'hFF);
		wr(IDX_RSV2, 8'hFF);
		rc(IDX_RSV1, 8'h00);
		rc(IDX_RSV2, 8'h00);
		rc(6'h14, 8'h00);
		rc(6'h20, 8'h00);
		tdone(1);
		cmd(1, 16'h0903, 16'h0000, 0, 0, 0, 0);
		go(8'hA0);
		wr(IDX_STATUS, 8'h00);
		rc(IDX_STATUS, 8'hA0);
		go(8'hA0);
		`CK("starts", 8'h00, nst)
		wr(IDX_STATUS, 8'h20);
		rc(IDX_STATUS, 8'h80);
		tdone(2);
		wr(IDX_CLKDIV, 8'h05);
		rc(IDX_CLKDIV, 8'h85);
		t0 = ticks;
		repeat (60) @(posedge clock);
		`CK("ticks", t0 + 10, ticks)
		go(8'h80);
		`CK("ops", 4'b0111, hist[3:0])
		`CK("scope", SC_BLOCK, scope)
		tdone(3);
		wr(IDX_CMDIDX, 8'h00);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		mode <= 1'b1;
		cmd(1, 16'h0A03, 16'h1230, 0, 0, 0, 0);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		mode <= 1'b0;
		cmd(1, 16'h0A03, 16'h1234, 0, 0, 0, 0);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		cmd(1, 16'h0903, 16'h0004, 0, 0, 0, 0);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		cmd(1, 16'h0901, 16'h0000, 0, 0, 0, 0);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		cmd(1, 16'h0900, 16'h0001, 0, 0, 0, 0);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		tdone(4);
		wr(IDX_PROT, 8'h08);
		cmd(1, 16'h0903, 16'h0000, 0, 0, 0, 0);
		go(8'h90);
		wr(IDX_STATUS, 8'h10);
		wr(IDX_PROT, 8'h00);
		bad <= 2'h3;
		go(8'h83);
		bad <= 2'h0;
		go(8'h80);
		tdone(5);
		cmd(1, 16'h0A03, 16'h1230, 0, 0, 0, 0);
		go(8'h80);
		`CK("scope", SC_SECTOR, scope)
		`CK("addr", 18'h31230, addr)
		slow <= 1'b1;
		wr(IDX_STATUS, 8'h80);
		wr(IDX_CMDIDX, 8'h03);
		wr(IDX_CMD_HI, 8'hFF);
		fin(8'h80);
		slow <= 1'b0;
		rc(IDX_CMDIDX, 8'h01);
		rc(IDX_CMD_HI, 8'h12);
		tdone(6);
		cmd(5, 16'h0603, 16'h0100, 16'h1122, 16'h3344, 16'h5566, 16'h7788);
		go(8'h80);
		`CK("scope", SC_PHRASE, scope)
		`CK("addr", 18'h30100, addr)
		`CK("data", 64'h1122334455667788, data)
		`CK("ops", 4'b1011, hist[3:0])
		wr(IDX_CMDIDX, 8'h04);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		cmd(5, 16'h0603, 16'h0104, 16'h1122, 16'h3344, 16'h5566, 16'h7788);
		go(8'hA0);
		wr(IDX_STATUS, 8'h20);
		wr(IDX_PROT, 8'h01);
		cmd(5, 16'h0603, 16'h0100, 16'h1122, 16'h3344, 16'h5566, 16'h7788);
		go(8'h90);
		wr(IDX_STATUS, 8'h10);
		wr(IDX_PROT, 8'h00);
		tdone(7);
		cmd(5, 16'h0700, 16'h0002, 16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0718);
		go(8'h80);
		`CK("ops", 6'b111011, hist[5:0])
		`CK("scope", SC_OTP, scope)
		`CK("addr", 18'h00002, addr)
		go(8'hA0);
		tdone(8);
		end_of_test();
	end
endmodule : tb
